// ---- rtl/dbs_port.sv ----
// Pin-level port of a two-word burst double-data-rate memory.
`timescale 1ns/1ns
module dbs_port import dbs_pkg::*; (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  main_strobe,
	input  wire logic                  main_strobe_n,
	input  wire logic                  out_strobe,
	input  wire logic                  out_strobe_n,
	input  wire logic                  pll_bypass_n,
	input  wire logic                  dir_read,
	input  wire logic                  load_n,
	input  wire logic [DBS_LANES-1:0]  byte_lane_select_n,
	input  wire logic [DBS_ADDR_W-1:0] addr,
	input  wire logic [DBS_WORD_W-1:0] dq_in,
	output logic      [DBS_WORD_W-1:0] dq_out,
	output logic                       dq_oe,
	output logic                       echo_strobe,
	output logic                       echo_strobe_n
);

	// Flips the lowest address bit.
	// The burst wraps inside its pair of words.
	function automatic logic [DBS_ADDR_W-1:0] burst_next(
		input logic [DBS_ADDR_W-1:0] a
	);
		burst_next = {a[DBS_ADDR_W-1:1], ~a[0]};
	endfunction

	// -----------------------------------------------
	// Pin synchronisation.
	// -----------------------------------------------

	// Raw pins, packed so one synchroniser serves all.
	logic [DBS_PIN_W-1:0] pin_raw;
	// Pins after two flip-flops.
	logic [DBS_PIN_W-1:0] pin_s;

	// Every pin sees the same delay, so data and
	// strobes keep their relative timing.
	assign pin_raw = {main_strobe, main_strobe_n,
		out_strobe, out_strobe_n, pll_bypass_n,
		dir_read, load_n, byte_lane_select_n,
		addr, dq_in};

	// Two flip-flops for every pin.
	dbs_sync #(
		.W (DBS_PIN_W)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.pin_in   (pin_raw),
		.pin_sync (pin_s)
	);

	// Unpacked synchronised pins.
	logic                  k_s;
	logic                  kn_s;
	logic                  c_s;
	logic                  cn_s;
	logic                  bypass_n_s;
	logic                  rd_s;
	logic                  load_n_s;
	logic [DBS_LANES-1:0]  bls_n_s;
	logic [DBS_ADDR_W-1:0] addr_s;
	logic [DBS_WORD_W-1:0] d_s;

	// Field split of the synchronised bundle.
	assign {k_s, kn_s, c_s, cn_s, bypass_n_s,
		rd_s, load_n_s, bls_n_s, addr_s, d_s} = pin_s;

	// -----------------------------------------------
	// Edge detection and clock mode.
	// -----------------------------------------------

	// Previous levels of the input strobes.
	logic k_q;
	logic kn_q;
	// Previous levels of the chosen output strobes.
	logic ot_q;
	logic of_q;
	// Strap state: caught once after reset.
	logic strap_done_q;
	logic single_q;

	// Output timing levels, from the pair in use.
	logic o_true;
	logic o_comp;

	// One-cycle pulses on each strobe rise.
	logic k_rise;
	logic kn_rise;
	logic o_rise;
	logic o_fall;

	// In single clock mode the input pair times the
	// outputs as well.
	assign o_true  = single_q ? k_s : c_s;
	assign o_comp  = single_q ? kn_s : cn_s;

	// Nothing counts before the strap is known.
	assign k_rise  = strap_done_q & k_s & ~k_q;
	assign kn_rise = strap_done_q & kn_s & ~kn_q;
	assign o_rise  = strap_done_q & o_true & ~ot_q;
	assign o_fall  = strap_done_q & o_comp & ~of_q;

	// Edge history and the mode strap.
	// The strap is sampled by a clocked process on the
	// first cycle after reset, never under reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			k_q          <= 1'b0;
			kn_q         <= 1'b0;
			ot_q         <= 1'b0;
			of_q         <= 1'b0;
			strap_done_q <= 1'b0;
			single_q     <= 1'b0;
		end else begin
			k_q  <= k_s;
			kn_q <= kn_s;
			ot_q <= o_true;
			of_q <= o_comp;
			if (!strap_done_q) begin
				// Both output strobes high means tied off.
				strap_done_q <= 1'b1;
				single_q     <= c_s & cn_s;
			end
		end
	end

	// -----------------------------------------------
	// Command decode.
	// -----------------------------------------------

	// A command is taken only on a main strobe rise.
	logic cmd_valid;
	logic cmd_rd;
	logic cmd_wr;
	// Legacy timing when the bypass pin is low.
	logic legacy;

	// Load high starts nothing; bursts run on.
	assign cmd_valid = k_rise & ~load_n_s;
	assign cmd_rd    = cmd_valid & rd_s;
	assign cmd_wr    = cmd_valid & ~rd_s;
	assign legacy    = ~bypass_n_s;

	// -----------------------------------------------
	// Read pipeline.
	// -----------------------------------------------

	// Stage p: read taken, waiting for the next rise.
	logic                  p_valid_q;
	logic [DBS_ADDR_W-1:0] p_addr_q;
	// Stage a: first word due on its output edge.
	logic                  a_valid_q;
	logic [DBS_ADDR_W-1:0] a_addr_q;
	// Stage s: second word due on the other edge.
	logic                  s_valid_q;
	logic [DBS_ADDR_W-1:0] s_addr_q;

	// Stage p moves to a on the next main strobe rise.
	logic                  a_load;
	logic                  a_avail;
	logic [DBS_ADDR_W-1:0] a_src;
	// Edges for the first and the second word.
	logic                  first_edge;
	logic                  second_edge;
	// Word launches.
	logic                  drv_first;
	logic                  drv_second;
	logic                  drv_any;

	assign a_load  = k_rise & p_valid_q;
	// In legacy mode the move and the launch can fall
	// in one cycle, so stage p is read straight through.
	assign a_avail = a_valid_q | a_load;
	assign a_src   = a_load ? p_addr_q : a_addr_q;

	// Normal timing: complement edge, then true edge.
	// Legacy: true edge with the strobe, then complement.
	assign first_edge  = legacy ? o_rise : o_fall;
	assign second_edge = legacy ? o_fall : o_rise;

	assign drv_first  = first_edge & a_avail;
	assign drv_second = second_edge & s_valid_q;
	assign drv_any    = drv_first | drv_second;

	// Stage p: a new read replaces the one just moved.
	always_ff @(posedge clk) begin
		if (rst) begin
			p_valid_q <= 1'b0;
			p_addr_q  <= DBS_ADDR_RST;
		end else if (cmd_rd) begin
			p_valid_q <= 1'b1;
			p_addr_q  <= addr_s;
		end else if (k_rise) begin
			p_valid_q <= 1'b0;
		end
	end

	// Stage a: loaded on the rise, freed by launch.
	always_ff @(posedge clk) begin
		if (rst) begin
			a_valid_q <= 1'b0;
			a_addr_q  <= DBS_ADDR_RST;
		end else if (drv_first) begin
			a_valid_q <= 1'b0;
		end else if (a_load) begin
			a_valid_q <= 1'b1;
			a_addr_q  <= p_addr_q;
		end
	end

	// Stage s: armed by the first word's launch.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_valid_q <= 1'b0;
			s_addr_q  <= DBS_ADDR_RST;
		end else if (drv_first) begin
			s_valid_q <= 1'b1;
			s_addr_q  <= burst_next(a_src);
		end else if (drv_second) begin
			s_valid_q <= 1'b0;
		end
	end

	// -----------------------------------------------
	// Write path.
	// -----------------------------------------------

	// Write taken, waiting for its first word.
	logic                  w_cmd_q;
	logic [DBS_ADDR_W-1:0] w_cmd_addr_q;
	// Address of the burst now receiving data.
	logic [DBS_ADDR_W-1:0] w_dat_addr_q;
	// Data phase state.
	dbs_wr_state_t         wr_state_q;
	dbs_wr_state_t         wr_state_d;

	// Word captures on the two input strobe rises.
	logic w1_take;
	logic w2_take;

	// Array write port.
	logic                  mem_we;
	logic [DBS_ADDR_W-1:0] mem_wr_addr;
	logic [DBS_LANES-1:0]  mem_lane_en;

	// Word one on the next main rise, word two on
	// the complement rise that follows it.
	assign w1_take = k_rise & w_cmd_q;
	assign w2_take = kn_rise & (wr_state_q == DBS_WR_SECOND);

	// Each word is written as it arrives.
	// Both land before the next rise, so the whole
	// 36-bit burst is in the array by then.
	assign mem_we      = w1_take | w2_take;
	assign mem_wr_addr = w1_take ? w_cmd_addr_q
		: burst_next(w_dat_addr_q);
	// Lane selects are active low and come with the word.
	assign mem_lane_en = ~bls_n_s;

	// Command stage: cleared on the rise that takes
	// its first word, unless a new write arrives.
	always_ff @(posedge clk) begin
		if (rst) begin
			w_cmd_q      <= 1'b0;
			w_cmd_addr_q <= DBS_ADDR_RST;
		end else if (cmd_wr) begin
			w_cmd_q      <= 1'b1;
			w_cmd_addr_q <= addr_s;
		end else if (k_rise) begin
			w_cmd_q <= 1'b0;
		end
	end

	// Burst address follows the first word.
	always_ff @(posedge clk) begin
		if (rst) begin
			w_dat_addr_q <= DBS_ADDR_RST;
		end else if (w1_take) begin
			w_dat_addr_q <= w_cmd_addr_q;
		end
	end

	// Data phase sequencing.
	// A first word always leads to a second; with no
	// new command the path then goes idle and the data
	// pins are no longer looked at.
	always_comb begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			DBS_WR_IDLE: begin
				if (w1_take) begin
					wr_state_d = DBS_WR_SECOND;
				end
			end
			DBS_WR_SECOND: begin
				if (w2_take) begin
					wr_state_d = DBS_WR_IDLE;
				end
			end
			default: begin
				wr_state_d = DBS_WR_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_state_q <= DBS_WR_IDLE;
		end else begin
			wr_state_q <= wr_state_d;
		end
	end

	// -----------------------------------------------
	// Array and read forwarding.
	// -----------------------------------------------

	// Read address of the word being launched.
	logic [DBS_ADDR_W-1:0] rd_addr;
	// Raw array word and forwarded word.
	logic [DBS_WORD_W-1:0] arr_data;
	logic [DBS_WORD_W-1:0] rd_word;
	// Same-cycle write to the word being read.
	logic                  fwd_hit;
	logic [DBS_WORD_W-1:0] lane_mask;

	assign rd_addr = drv_first ? a_src : s_addr_q;

	// The array reads old data in a write cycle, so
	// the lanes just written are taken from the pins.
	assign fwd_hit   = mem_we & (mem_wr_addr == rd_addr);
	assign lane_mask = {{DBS_LANE_W{mem_lane_en[1]}},
		{DBS_LANE_W{mem_lane_en[0]}}};
	assign rd_word   = fwd_hit ? ((d_s & lane_mask)
		| (arr_data & ~lane_mask)) : arr_data;

	// Storage for both lanes.
	dbs_array u_array (
		.clk        (clk),
		.we         (mem_we),
		.wr_addr    (mem_wr_addr),
		.wr_data    (d_s),
		.wr_lane_en (mem_lane_en),
		.rd_addr    (rd_addr),
		.rd_data    (arr_data)
	);

	// -----------------------------------------------
	// Output registers.
	// -----------------------------------------------

	// Data pins: a word goes out on its edge and the
	// drive stays on until a true edge with no word.
	// Dropping it then frees the bus for another bank
	// with no wait states.
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_out <= DBS_DQ_RST;
			dq_oe  <= 1'b0;
		end else if (drv_any) begin
			dq_out <= rd_word;
			dq_oe  <= 1'b1;
		end else if (o_rise) begin
			dq_oe <= 1'b0;
		end
	end

	// Echo strobes copy the output timing pair; they
	// run whether or not data is moving.
	always_ff @(posedge clk) begin
		if (rst) begin
			echo_strobe   <= 1'b0;
			echo_strobe_n <= 1'b0;
		end else begin
			echo_strobe   <= o_true;
			echo_strobe_n <= o_comp;
		end
	end

	// The controller idles between a read and a write
	// so the data pins are never driven by both ends;
	// nothing here arbitrates that bus.

endmodule // dbs_port

// ---- rtl/dbs_pkg.sv ----
// Shared constants and types for the two-word burst memory port.
// Notes on behaviour
// - Bypass high: read data after 1.5 cycles.
// - Bypass low: legacy mode, one cycle latency.
// - Accesses start only on main strobe rise.
// - Output data timed by output strobe pair.
// - Write words captured on both strobe rises.
// - Control sampled only on main strobe rise.
// - Every access moves exactly two 18-bit words.
// - Read: direction high, load low; store address.
// - Second address flips lowest address bit.
// - First word complement edge, second true edge.
// - Reads accepted on every main strobe rise.
// - Idle reads: tristate after next true edge.
// - Write: direction low, load low; store address.
// - Two write words committed, 36 bits total.
// - Back-to-back writes pipeline one word per edge.
// - Deselected writes finish, then inputs ignored.
// - Lane selects sampled with each write word.
// - Deselected lane keeps its stored byte.
// - Lane 0 bits 8:0, lane 1 bits 17:9.
// - Read after write returns the newest data.
package dbs_pkg;

	localparam int DBS_ADDR_W  = 21;
	localparam int DBS_WORD_W  = 18;
	localparam int DBS_LANES   = 2;
	localparam int DBS_LANE_W  = 9;
	localparam int DBS_DEPTH   = 2097152;
	localparam int DBS_SYNC_N  = 2;
	localparam int DBS_CLK_N   = 5;
	localparam int DBS_PIN_W   = DBS_CLK_N + 2 + DBS_LANES + DBS_ADDR_W + DBS_WORD_W;

	localparam logic [DBS_WORD_W-1:0] DBS_DQ_RST = 18'h00000;
	localparam logic [DBS_ADDR_W-1:0] DBS_ADDR_RST = 21'h000000;

	// Write data path: idle, or waiting for the second word.
	typedef enum logic [1:0] {
		DBS_WR_IDLE   = 2'b01,
		DBS_WR_SECOND = 2'b10
	} dbs_wr_state_t;

endpackage

// ---- rtl/dbs_sync.sv ----
// Two-stage synchroniser for a bundle of pin levels.
`timescale 1ns/1ns
module dbs_sync import dbs_pkg::*; #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);

	// First stage; only the second stage reads it.
	logic [W-1:0] meta_q;

	// No reset: both stages keep following the pins through reset, so the
	// mode strap is already valid on the first cycle after release.
	// Stray edges are masked in the port until the strap has been taken.
	always_ff @(posedge clk) begin
		meta_q   <= pin_in;
		pin_sync <= meta_q;
	end

endmodule // dbs_sync

// ---- rtl/dbs_array.sv ----
// Storage array with one byte-lane write port and one read port.
`timescale 1ns/1ns
module dbs_array import dbs_pkg::*; (
	input  wire logic                  clk,
	input  wire logic                  we,
	input  wire logic [DBS_ADDR_W-1:0] wr_addr,
	input  wire logic [DBS_WORD_W-1:0] wr_data,
	input  wire logic [DBS_LANES-1:0]  wr_lane_en,
	input  wire logic [DBS_ADDR_W-1:0] rd_addr,
	output logic      [DBS_WORD_W-1:0] rd_data
);

	// One array per byte lane, so a lane can be skipped.
	logic [DBS_LANE_W-1:0] mem [DBS_LANES][DBS_DEPTH];

	// A lane with its enable low keeps its old byte.
	always_ff @(posedge clk) begin
		for (int i = 0; i < DBS_LANES; i++) begin
			if (we && wr_lane_en[i]) begin
				mem[i][wr_addr] <= wr_data[i*DBS_LANE_W +: DBS_LANE_W];
			end
		end
	end

	// Lane 0 holds the low nine bits, lane 1 the high nine.
	assign rd_data = {mem[1][rd_addr], mem[0][rd_addr]};

endmodule // dbs_array

// ---- testbench/dbs_port_sva.sv ----
// Pin-level assertions for the two-word burst memory port.
`timescale 1ns/1ns
module dbs_port_sva import dbs_pkg::*; (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  main_strobe,
	input wire logic                  main_strobe_n,
	input wire logic                  out_strobe,
	input wire logic                  out_strobe_n,
	input wire logic                  pll_bypass_n,
	input wire logic                  dir_read,
	input wire logic                  load_n,
	input wire logic [DBS_LANES-1:0]  byte_lane_select_n,
	input wire logic [DBS_ADDR_W-1:0] addr,
	input wire logic [DBS_WORD_W-1:0] dq_in,
	input wire logic [DBS_WORD_W-1:0] dq_out,
	input wire logic                  dq_oe,
	input wire logic                  echo_strobe,
	input wire logic                  echo_strobe_n
);
	logic [2:0] rel_q;    // Cycles since reset release, saturating at seven.
	logic [7:0] rd_age_q; // Cycles since a read command stood at a main rise.
	logic [7:0] rd_lead_q; // Cycles since the read that opened a run of back-to-back reads.
	logic       ms_q;     // Previous main strobe level.
	wire        rd_cmd  = main_strobe && !ms_q && !load_n && dir_read;
	// A tied-high output pair means single clock mode, where the input pair times outputs.
	wire        o_tim   = (out_strobe && out_strobe_n) ? main_strobe : out_strobe;
	wire        o_tim_n = (out_strobe && out_strobe_n) ? main_strobe_n : out_strobe_n;
	wire        settled = (rel_q == 3'h7);

	// Helper counters; the age saturates so a long idle spell never wraps to a young value.
	always_ff @(posedge clk) begin
		ms_q <= main_strobe;
		if (rst) begin
			rel_q    <= 3'h0;
			rd_age_q <= 8'hFF;
			rd_lead_q <= 8'hFF;
		end else begin
			rel_q    <= settled ? rel_q : rel_q + 3'h1;
			// A read one period after another joins its burst stream and does not restart.
			rd_lead_q <= (rd_cmd && rd_age_q > 8'h08) ? 8'h00
				: (rd_lead_q == 8'hFF ? rd_lead_q : rd_lead_q + 8'h01);
			rd_age_q <= rd_cmd ? 8'h00 : (rd_age_q == 8'hFF ? rd_age_q : rd_age_q + 8'h01);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// A read burst keeps the pins driven for at least one full strobe period.
	sequence s_burst;
		dq_oe [*8];
	endsequence
	// An output timing edge reached the pins two or three cycles before.
	sequence s_out_edge;
		($past(o_tim, 3) != $past(o_tim, 4)) || ($past(o_tim, 2) != $past(o_tim, 3));
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !dq_oe && dq_out == DBS_DQ_RST && !echo_strobe && !echo_strobe_n)
		else $error("outputs not quiet in reset");
	a_echo_true: assert property (settled |-> echo_strobe == $past(o_tim, 3))
		else $error("echo strobe does not follow output timing");
	a_echo_comp: assert property (settled |-> echo_strobe_n == $past(o_tim_n, 3))
		else $error("echo complement does not follow output timing");
	a_oe_rise_win: assert property ($rose(dq_oe) |-> rd_lead_q inside {[8'd9:8'd17]})
		else $error("data drive starts at the wrong distance from a read");
	a_oe_fall_win: assert property (settled && $fell(dq_oe) |-> rd_age_q inside {[8'd17:8'd30]})
		else $error("data drive ends at the wrong distance from a read");
	a_burst_hold: assert property ($rose(dq_oe) |-> s_burst)
		else $error("read burst cut short");
	a_word_on_edge: assert property (settled && dq_oe && $changed(dq_out) |-> s_out_edge)
		else $error("read word changed away from an output timing edge");
	a_idle_quiet: assert property (rd_age_q > 8'd34 |-> !dq_oe)
		else $error("data pins driven with no read pending");
endmodule // dbs_port_sva

bind dbs_port dbs_port_sva u_sva (.clk, .rst, .main_strobe, .main_strobe_n, .out_strobe,
	.out_strobe_n, .pll_bypass_n, .dir_read, .load_n, .byte_lane_select_n, .addr, .dq_in,
	.dq_out, .dq_oe, .echo_strobe, .echo_strobe_n);

// ---- testbench/dbs_ctrl_model.sv ----
// Far-side controller model: makes the input and output strobe pairs.
`timescale 1ns/1ns
module dbs_ctrl_model (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       single,
	output logic      [2:0] ph,
	output logic            main_strobe,
	output logic            main_strobe_n,
	output logic            out_strobe,
	output logic            out_strobe_n
);
	logic [2:0] ph_q  = 3'h0; // Phase in a strobe period of eight system cycles.
	logic       run_q = 1'b0; // Strobes run only while set; they stand still otherwise.

	// Phase stays at zero while stopped, so the first rise after a start is a clean period.
	always_ff @(posedge clk) begin
		run_q <= run;
		ph_q  <= run_q ? ph_q + 3'h1 : 3'h0;
	end

	// Accesses can only begin at the main rise, which falls at phase zero.
	assign main_strobe   = run_q && !ph_q[2];
	assign main_strobe_n = !main_strobe;
	// Output pair aligned with the input pair; tied high together for single clock mode.
	assign out_strobe    = single || main_strobe;
	assign out_strobe_n  = single || main_strobe_n;
	assign ph            = ph_q;
endmodule // dbs_ctrl_model

// ---- testbench/dbs_port_tb.sv ----
// Self-checking bench for the burst memory port: a table of strobe periods, then reset cases.
`timescale 1ns/1ns
module dbs_port_tb import dbs_pkg::*; ;
	// One strobe period: command, word at main rise, word at complement rise, expected reads.
	typedef struct packed {
		logic                  ld;
		logic                  rd;
		logic [DBS_ADDR_W-1:0] a;
		logic [DBS_WORD_W-1:0] dh;
		logic [DBS_LANES-1:0]  bh;
		logic [DBS_WORD_W-1:0] dl;
		logic [DBS_LANES-1:0]  bl;
		logic                  oa;
		logic [DBS_WORD_W-1:0] qa;
		logic                  ob;
		logic [DBS_WORD_W-1:0] qb;
	} dbs_row_t;
	localparam int N_ROWS = 15;
	// Writes with lane masking, back-to-back reads, legacy latency, read right after write.
	dbs_row_t rows [N_ROWS] = '{
		'{1'h0,1'h0,21'h000010,18'h2AAAA,2'h3,18'h15555,2'h3,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h0,1'h0,21'h000011,18'h12345,2'h0,18'h0ABCD,2'h0,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h1,1'h1,21'h1FFFFF,18'h3FFFF,2'h1,18'h00000,2'h2,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h0,1'h1,21'h000011,18'h0F0F0,2'h0,18'h30303,2'h0,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h0,1'h1,21'h000010,18'h0F0F0,2'h0,18'h30303,2'h0,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h1,1'h0,21'h000011,18'h3FFFF,2'h0,18'h00000,2'h0,1'h1,18'h3FFCD,1'h1,18'h12200},
		'{1'h1,1'h1,21'h000000,18'h15555,2'h0,18'h2AAAA,2'h0,1'h1,18'h12200,1'h1,18'h3FFCD},
		'{1'h1,1'h0,21'h000000,18'h00000,2'h3,18'h00000,2'h3,1'h1,18'h3FFCD,1'h0,18'h00000},
		'{1'h1,1'h0,21'h000000,18'h00000,2'h3,18'h00000,2'h3,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h0,1'h1,21'h000011,18'h00000,2'h3,18'h00000,2'h3,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h1,1'h1,21'h000011,18'h00000,2'h3,18'h00000,2'h3,1'h0,18'h00000,1'h1,18'h3FFCD},
		'{1'h0,1'h0,21'h000030,18'h00000,2'h3,18'h00000,2'h3,1'h1,18'h12200,1'h0,18'h00000},
		'{1'h0,1'h1,21'h000030,18'h00111,2'h0,18'h00222,2'h0,1'h0,18'h00000,1'h0,18'h00000},
		'{1'h1,1'h0,21'h000030,18'h00000,2'h3,18'h00000,2'h3,1'h0,18'h00000,1'h1,18'h00111},
		'{1'h1,1'h0,21'h000030,18'h00000,2'h3,18'h00000,2'h3,1'h1,18'h00222,1'h0,18'h00000}
	}; // Row 10 is the idle period between a read and a write.

	logic                  clk;
	logic                  rst                = 1'b1;
	logic                  run                = 1'b0;
	logic                  single             = 1'b0;
	logic [2:0]            ph;
	logic                  main_strobe;
	logic                  main_strobe_n;
	logic                  out_strobe;
	logic                  out_strobe_n;
	logic                  pll_bypass_n       = 1'b1;
	logic                  dir_read           = 1'b0;
	logic                  load_n             = 1'b1;
	logic [DBS_LANES-1:0]  byte_lane_select_n = 2'h3;
	logic [DBS_ADDR_W-1:0] addr               = 21'h000000;
	logic [DBS_WORD_W-1:0] dq_in              = 18'h00000;
	logic [DBS_WORD_W-1:0] dq_out;
	logic                  dq_oe;
	logic                  echo_strobe;
	logic                  echo_strobe_n;
	int                    err_total          = 0;
	int                    cmp_count          = 0;

	dbs_ctrl_model u_ctrl (.clk, .run, .single, .ph, .main_strobe, .main_strobe_n, .out_strobe,
		.out_strobe_n);
	dbs_port dut (.clk, .rst, .main_strobe, .main_strobe_n, .out_strobe, .out_strobe_n,
		.pll_bypass_n, .dir_read, .load_n, .byte_lane_select_n, .addr, .dq_in, .dq_out,
		.dq_oe, .echo_strobe, .echo_strobe_n);

	// System clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Prints the counts and the verdict; the only place the run ends.
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Compares the read data pins.
	task automatic chk_q(input logic [DBS_WORD_W-1:0] exp, input string what);
		cmp_count++;
		if (dq_out !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s is %h, expected %h", $time, what, dq_out, exp);
		end
	endtask

	// Compares a single output flag.
	task automatic chk_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s is %b, expected %b", $time, what, got, exp);
		end
	endtask

	// Waits for the edge that ends a strobe phase; a stuck strobe ends the run.
	task automatic wait_ph(input logic [2:0] k);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ph !== k && n < 20);
		if (ph !== k) begin
			err_total++;
			$display("wrong value at %0t: strobe phase never reached", $time);
			wrap_up();
		end
	endtask

	// Puts a command and the word due at the next main rise, mid-way between strobe edges.
	task automatic put_cmd(input int i);
		load_n             <= rows[i].ld;
		dir_read           <= rows[i].rd;
		addr               <= rows[i].a;
		dq_in              <= rows[i].dh;
		byte_lane_select_n <= rows[i].bh;
	endtask

	// Main sequence: reset, the table of periods, then a reset in mid-burst.
	initial begin
		repeat (10) @(posedge clk);
		chk_bit(dq_oe, 1'b0, "drive in reset");
		chk_bit(echo_strobe, 1'b0, "echo in reset");
		chk_q(DBS_DQ_RST, "data in reset");
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		run <= 1'b1;
		wait_ph(3'h5);
		put_cmd(0);
		for (int i = 0; i < N_ROWS; i++) begin
			wait_ph(3'h1);
			dq_in              <= rows[i].dl;
			byte_lane_select_n <= rows[i].bl;
			pll_bypass_n       <= (i < 8);
			#1;
			chk_bit(dq_oe, rows[i].oa, "drive after complement edge");
			if (rows[i].oa === 1'b1)
				chk_q(rows[i].qa, "word after complement edge");
			wait_ph(3'h5);
			put_cmd(i + 1 < N_ROWS ? i + 1 : N_ROWS - 1);
			#1;
			chk_bit(dq_oe, rows[i].ob, "drive after true edge");
			if (rows[i].ob === 1'b1)
				chk_q(rows[i].qb, "word after true edge");
		end
		$display("table of periods done");
		wait_ph(3'h5);
		load_n   <= 1'b0;
		dir_read <= 1'b1;
		addr     <= 21'h000010;
		wait_ph(3'h1);
		load_n   <= 1'b1;
		// Legacy word one leaves on the true edge of the period after the command.
		wait_ph(3'h5);
		wait_ph(3'h5);
		#1;
		chk_bit(dq_oe, 1'b1, "drive before reset");
		chk_q(18'h12200, "word before reset");
		@(posedge clk);
		rst    <= 1'b1;
		run    <= 1'b0;
		single <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk_bit(dq_oe, 1'b0, "drive in mid reset");
		chk_q(DBS_DQ_RST, "data in mid reset");
		@(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		run <= 1'b1;
		repeat (24) @(posedge clk);
		#1;
		chk_bit(dq_oe, 1'b0, "drive after mid reset");
		$display("mid-burst reset done");
		// Output pair tied high through reset: the input pair must now time the data.
		wait_ph(3'h5);
		load_n   <= 1'b0;
		dir_read <= 1'b1;
		addr     <= 21'h000011;
		wait_ph(3'h1);
		load_n   <= 1'b1;
		wait_ph(3'h5);
		wait_ph(3'h5);
		#1;
		chk_bit(dq_oe, 1'b1, "drive in single clock mode");
		chk_q(18'h3FFCD, "word in single clock mode");
		$display("single clock read done");
		wrap_up();
	end
endmodule // dbs_port_tb
